// ===== design/bscg_pkg.sv
package bscg_pkg;

   // Clock rate and blink timing
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned BLINK_HZ      = 8;
   localparam int unsigned BLINK_HALF    = CLK_HZ / (2 * BLINK_HZ);
   localparam int unsigned BLINK_CNT_W   = 23;
   localparam logic [BLINK_CNT_W-1:0] BLINK_LAST = BLINK_CNT_W'(BLINK_HALF - 1);

   // Reset values
   localparam logic RST_LAMP     = 1'b0;
   localparam logic RST_RAILS    = 1'b0;
   localparam logic RST_PROG_N   = 1'b1;

   // Lines from the FPGA over the internal pairs
   typedef struct packed {
      logic link0_pos;
      logic link1_pos;
      logic link1_neg;
      logic link2_neg;
      logic link3_pos;
      logic link3_neg_printed;
      logic link4_pos;
      logic link5_neg;
   } bscg_from_fpga_t;

   // Lines back toward the FPGA
   typedef struct packed {
      logic link2_pos;
      logic link4_neg;
      logic link5_pos;
      logic link_direction;
   } bscg_to_fpga_t;

   // Synthesizer control lines
   typedef struct packed {
      logic synth_serial_clk;
      logic synth_serial_io;
      logic synth_serial_io_oe;
      logic synth_select;
      logic synth_align;
      logic synth_rst;
   } bscg_synth_t;

   // Rail enables
   typedef struct packed {
      logic rail_low_enable;
      logic rail_mid_enable;
      logic rail_mezz_enable;
   } bscg_rails_t;

   // Board inputs that pass the synchroniser
   typedef struct packed {
      logic fan_tach_in;
      logic slot_reset_n;
      logic mezz_present_n;
      logic button_n;
      logic config_done;
      logic synth_serial_io;
   } bscg_pins_t;

endpackage

// ===== design/bscg_top.sv
`timescale 1ns/1ps
module bscg_top (
   // Clock and reset
   input  wire logic                     clk_in,
   input  wire logic                     nrst_in,
   // Internal pairs
   input  wire bscg_pkg::bscg_from_fpga_t from_fpga_in,
   output      bscg_pkg::bscg_to_fpga_t   to_fpga_out,
   // Board pins
   input  wire logic                     fan_tach_in,
   output      logic                     fan_drive_out,
   input  wire logic                     slot_reset_n_in,
   input  wire logic                     mezz_present_n_in,
   input  wire logic                     button_n_in,
   input  wire logic                     config_done_in,
   output      logic                     fpga_prog_n_out,
   output      logic                     status_lamp_out,
   // Synthesizer
   output      bscg_pkg::bscg_synth_t     synth_out,
   input  wire logic                     synth_serial_io_in,
   input  wire logic [1:0]               synth_status_in,
   // Power
   output      bscg_pkg::bscg_rails_t     rails_out,
   input  wire logic [2:0]               rail_good_in,
   input  wire logic [1:0]               converter_alert_n_in
);
   import bscg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   logic [1:0]               rst_sync;
   logic                     rst_n;
   assign rst_n = rst_sync[1];

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser: three stages, change accepted when 2nd and 3rd agree
   bscg_pins_t               raw;
   bscg_pins_t               s1;
   bscg_pins_t               s2;
   bscg_pins_t               s3;
   bscg_pins_t               pin;
   bscg_pins_t               next_pin;

   assign raw = '{fan_tach_in:     fan_tach_in,
                  slot_reset_n:    slot_reset_n_in,
                  mezz_present_n:  mezz_present_n_in,
                  button_n:        button_n_in,
                  config_done:     config_done_in,
                  synth_serial_io: synth_serial_io_in};
   assign next_pin = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pin);

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s1  <= '1;
         s2  <= '1;
         s3  <= '1;
         pin <= '1;
      end else begin
         s1  <= raw;
         s2  <= s1;
         s3  <= s2;
         pin <= next_pin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Blink divider; a one-cycle toggle enable, not a derived clock
   logic [BLINK_CNT_W-1:0]   blink_cnt;
   logic                     blink_tick;
   logic                     blink_phase;
   logic                     unconfigured;
   logic                     pressed;
   logic                     next_lamp;
   logic                     next_prog_n;

   assign blink_tick   = (blink_cnt == BLINK_LAST);
   assign unconfigured = !pin.config_done;
   assign pressed      = !pin.button_n;
   // Blink has priority; the user term applies only after configuration
   assign next_lamp    = unconfigured ? blink_phase
                                      : (pressed | from_fpga_in.link0_pos);
   assign next_prog_n  = !pressed;

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         blink_cnt   <= '0;
         blink_phase <= 1'b0;
      end else begin
         blink_cnt   <= blink_tick ? '0 : blink_cnt + 1'b1;
         blink_phase <= blink_phase ^ (blink_tick & unconfigured);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered pass-through; one clock of latency behind the pairs and the synchronised pins
   // Status, alert and power-good inputs are deliberately left unread
   logic                     io_oe;
   assign io_oe = 1'b1;  // FPGA owns the data line; read-back is the pin level

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         to_fpga_out     <= '0;
         fan_drive_out   <= 1'b0;
         fpga_prog_n_out <= RST_PROG_N;
         status_lamp_out <= RST_LAMP;
         synth_out       <= '0;
         rails_out       <= {3{RST_RAILS}};
      end else begin
         to_fpga_out.link5_pos      <= pin.fan_tach_in;
         fan_drive_out              <= from_fpga_in.link5_neg;
         to_fpga_out.link4_neg      <= pin.slot_reset_n;
         to_fpga_out.link2_pos      <= pin.synth_serial_io;
         to_fpga_out.link_direction <= pin.mezz_present_n;
         fpga_prog_n_out            <= next_prog_n;
         status_lamp_out            <= next_lamp;
         synth_out.synth_serial_clk <= from_fpga_in.link1_pos;
         synth_out.synth_serial_io  <= from_fpga_in.link1_neg;
         synth_out.synth_serial_io_oe <= io_oe;
         synth_out.synth_select     <= from_fpga_in.link3_pos;
         synth_out.synth_align      <= from_fpga_in.link3_neg_printed;
         synth_out.synth_rst        <= from_fpga_in.link4_pos;
         rails_out                  <= 3'h7;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Registered outputs keep reset values only until the first edge after release; checks wait two
   logic [1:0]               chk_arm;

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         chk_arm <= 2'h0;
      end else begin
         chk_arm <= {chk_arm[0], 1'b1};
      end
   end

   a_tach_path: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      to_fpga_out.link5_pos == $past(pin.fan_tach_in))
      else $error("fan tach not forwarded");

   a_prog_idle: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      $past(!pressed) |-> fpga_prog_n_out)
      else $error("reprogram line asserted without press");

   a_lamp_press: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      ($past(pressed) && $past(!unconfigured)) |-> status_lamp_out)
      else $error("lamp dark on press");

   a_blink_hold: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      ($past(unconfigured) && $past(unconfigured, 2) && !$past(blink_tick, 2))
         |-> $stable(status_lamp_out))
      else $error("lamp changed between blink ticks");

   a_serial_lines: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      {synth_out.synth_serial_clk, synth_out.synth_serial_io} ==
      $past({from_fpga_in.link1_pos, from_fpga_in.link1_neg}))
      else $error("synth serial lines wrong");

   a_rails_hold: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      ($past(rails_out) == 3'h7) |-> (rails_out == 3'h7))
      else $error("rails dropped after start-up");

   a_fan_path: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      fan_drive_out == $past(from_fpga_in.link5_neg))
      else $error("fan drive does not follow pair five");

   a_button_prog: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      $past(pressed) |-> !fpga_prog_n_out)
      else $error("reprogram line not asserted on press");

   a_blink_rate: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      ($past(unconfigured) && $past(blink_tick, 2) && $past(unconfigured, 2))
         |-> (status_lamp_out != $past(status_lamp_out)))
      else $error("lamp did not toggle while unconfigured");

   a_lamp_user: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      $past(!unconfigured) |->
         (status_lamp_out == ($past(pressed) | $past(from_fpga_in.link0_pos))))
      else $error("lamp not button or pair zero");

   a_slot_reset: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      to_fpga_out.link4_neg == $past(pin.slot_reset_n))
      else $error("slot reset not copied");

   a_synth_lines: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      {synth_out.synth_select, synth_out.synth_align, synth_out.synth_rst} ==
      $past({from_fpga_in.link3_pos, from_fpga_in.link3_neg_printed,
             from_fpga_in.link4_pos}))
      else $error("synth control lines wrong");

   a_sdio_back: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      to_fpga_out.link2_pos == $past(pin.synth_serial_io))
      else $error("serial data not returned");

   a_rails_on: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      rails_out == 3'h7 || rails_out == 3'h0)
      else $error("rails not enabled together");

   a_blink_stop: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      (!unconfigured && $past(!unconfigured)) |=> $stable(blink_phase))
      else $error("blink continued after done");

   a_direction: assert property (@(posedge clk_in) disable iff (!chk_arm[1])
      to_fpga_out.link_direction == $past(pin.mezz_present_n))
      else $error("direction not from presence");

endmodule

// ===== dv/bscg_fpga_model.sv
`timescale 1ns/1ps
module bscg_fpga_model (
   // Clock
   input  wire logic                      clk_in,
   // Levels the bench wants on the pairs
   input  wire bscg_pkg::bscg_from_fpga_t want_in,
   // Pairs toward the controller
   output      bscg_pkg::bscg_from_fpga_t lines_out
);
   import bscg_pkg::*;
   bscg_from_fpga_t next_lines;
   // Readback return pair kept low, the controller may not see otherwise
   always_comb begin
      next_lines           = want_in;
      next_lines.link2_neg = 1'b0;
   end
   // Registered, so the pairs move just after an edge like fabric flops
   always_ff @(posedge clk_in) begin
      lines_out <= next_lines;
   end
endmodule

// ===== dv/board_system_controller_glue_test.sv
`timescale 1ns/1ps
module board_system_controller_glue_test;
   import bscg_pkg::*;
   logic            clk_in;
   logic            nrst_in;
   logic            fan_tach;
   logic            slot_rst_n;
   logic            mezz_n;
   logic            button_n;
   logic            cfg_done;
   logic            fan_drive;
   logic            prog_n;
   logic            lamp;
   logic            io_wire;
   logic [1:0]      synth_status;
   logic [2:0]      rail_good;
   logic [1:0]      alert_n;
   bscg_from_fpga_t want;
   bscg_from_fpga_t lines;
   bscg_to_fpga_t   to_fpga;
   bscg_synth_t     synth;
   bscg_rails_t     rails;
   int              fails;
   int              comparisons;
   // Data pin has a pull-up when nobody drives it
   assign io_wire = synth.synth_serial_io_oe ? synth.synth_serial_io : 1'b1;
   bscg_fpga_model fpga (.clk_in(clk_in), .want_in(want), .lines_out(lines));
   bscg_top uut (.clk_in(clk_in), .nrst_in(nrst_in), .from_fpga_in(lines),
      .to_fpga_out(to_fpga), .fan_tach_in(fan_tach), .fan_drive_out(fan_drive),
      .slot_reset_n_in(slot_rst_n), .mezz_present_n_in(mezz_n), .button_n_in(button_n),
      .config_done_in(cfg_done), .fpga_prog_n_out(prog_n), .status_lamp_out(lamp),
      .synth_out(synth), .synth_serial_io_in(io_wire), .synth_status_in(synth_status),
      .rails_out(rails), .rail_good_in(rail_good), .converter_alert_n_in(alert_n));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic got, input logic exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask
   task results;
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Walking one over the pairs; pins, status, alerts and power-good churn meanwhile
   task t_pass;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_in);
         want         <= bscg_from_fpga_t'(8'h01 << i);
         fan_tach     <= i[0];
         slot_rst_n   <= i[1];
         mezz_n       <= i[2];
         synth_status <= i[1:0];
         alert_n      <= i[2:1];
         rail_good    <= i[2:0];
         repeat (10) @(posedge clk_in);
         #1;
         chk(fan_drive, want.link5_neg, "fan drive");
         chk(to_fpga.link5_pos, i[0], "fan tach");
         chk(to_fpga.link4_neg, i[1], "slot reset");
         chk(to_fpga.link_direction, i[2], "direction");
         chk(synth.synth_serial_clk, want.link1_pos, "serial clock");
         chk(synth.synth_serial_io, want.link1_neg, "serial data");
         chk(synth.synth_serial_io_oe, 1'b1, "data enable");
         chk(synth.synth_select, want.link3_pos, "select");
         chk(synth.synth_align, want.link3_neg_printed, "align");
         chk(synth.synth_rst, want.link4_pos, "synth reset");
         chk(to_fpga.link2_pos, want.link1_neg, "readback");
         chk(&rails, 1'b1, "rails");
      end
   endtask
   task lamp_step(input logic b_n, input logic l0, input logic cd);
      @(posedge clk_in);
      button_n       <= b_n;
      want.link0_pos <= l0;
      cfg_done       <= cd;
      repeat (10) @(posedge clk_in);
      #1;
   endtask
   // Lamp sources, then blink override far inside its first half period
   task t_lamp;
      lamp_step(1'b0, 1'b0, 1'b1);
      chk(prog_n, 1'b0, "prog on press");
      chk(lamp, 1'b1, "lamp on press");
      lamp_step(1'b1, 1'b1, 1'b1);
      chk(prog_n, 1'b1, "prog released");
      chk(lamp, 1'b1, "lamp from pair");
      lamp_step(1'b1, 1'b0, 1'b1);
      chk(lamp, 1'b0, "lamp off");
      lamp_step(1'b0, 1'b1, 1'b0);
      chk(prog_n, 1'b0, "prog unconfigured");
      chk(lamp, 1'b0, "blink phase");
      lamp_step(1'b0, 1'b1, 1'b1);
      chk(lamp, 1'b1, "blink stopped");
   endtask
   // Mid-run reset: outputs fall back, then all three rails rise on one edge
   task t_reset;
      @(posedge clk_in);
      nrst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      chk(|rails, 1'b0, "rails off in reset");
      chk(prog_n, 1'b1, "prog idle in reset");
      chk(synth.synth_serial_io_oe, 1'b0, "data released in reset");
      @(posedge clk_in);
      nrst_in <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_in);
         #1;
         chk((&rails) | (~|rails), 1'b1, "rails apart");
      end
      chk(&rails, 1'b1, "rails up");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Whole run needs well under 300 cycles
   initial begin
      #20000;
      fails++;
      results;
   end
   initial begin
      nrst_in      = 1'b0;
      want         = '0;
      fan_tach     = 1'b0;
      slot_rst_n   = 1'b1;
      mezz_n       = 1'b1;
      button_n     = 1'b1;
      cfg_done     = 1'b1;
      synth_status = 2'h0;
      rail_good    = 3'h0;
      alert_n      = 2'h3;
      fails        = 0;
      comparisons  = 0;
      repeat (16) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      t_pass;
      t_lamp;
      t_reset;
      results;
   end
endmodule
